// ==== pms_pkg.sv ====
// Shared constants and types for the power monitor state and accumulate block
package pms_pkg;
	typedef enum logic [1:0] {
		PMS_SLEEP = 2'b00,
		PMS_WAKE  = 2'b01,
		PMS_INTEG = 2'b11,
		PMS_READ  = 2'b10
	} pms_state_e;

	// Clock and times
	localparam int CLK_MHZ     = 100;
	localparam int T_READ_NS   = 10000;
	localparam int T_SLEEP_NS  = 1000000;
	localparam int T_WAKE_NS   = 5000;
	localparam int T_CONV11_NS = 1000;
	localparam int T_CONV14_NS = 8000;
	localparam int READ_CYC    = (T_READ_NS * CLK_MHZ + 999) / 1000;
	localparam int SLEEP_CYC   = (T_SLEEP_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_CYC    = (T_WAKE_NS * CLK_MHZ) / 1000;
	localparam int CONV11_CYC  = (T_CONV11_NS * CLK_MHZ + 999) / 1000;
	localparam int CONV14_CYC  = (T_CONV14_NS * CLK_MHZ + 999) / 1000;
	localparam int MAX_SAMPLES = 2048;

	// Register offsets
	localparam int          AXI_ADDR_W   = 8;
	localparam logic [7:0]  ADDR_CONTROL = 8'h00;
	localparam logic [7:0]  ADDR_GAIN    = 8'h04;
	localparam logic [7:0]  ADDR_STATUS  = 8'h08;
	localparam logic [7:0]  ADDR_PWR_RES = 8'h0c;
	localparam logic [7:0]  ADDR_SNS_RES = 8'h10;
	localparam logic [7:0]  ADDR_BUS_RES = 8'h14;
	localparam logic [7:0]  ADDR_DAC     = 8'h18;

	// Control fields
	localparam int CTL_OVR     = 0;
	localparam int CTL_INT_EN  = 1;
	localparam int CTL_SLEEP   = 2;
	localparam int CTL_MEAS_LO = 3;
	localparam int CTL_FSR_LO  = 5;
	localparam int CTL_SMPL_LO = 7;
	localparam int CTL_SRES14  = 11;
	localparam int CTL_BRES14  = 12;
	localparam int CTL_SFILT   = 13;
	localparam int CTL_BFILT   = 14;
	localparam logic [31:0] CTL_MASK = 32'h0000_7fff;
	localparam logic [31:0] CTL_RST  = 32'h0000_0000;

	// Gain fields
	localparam int GAIN_CUR_LO = 0;
	localparam int GAIN_VOL_LO = 3;
	localparam logic [31:0] GAIN_MASK = 32'h0000_003f;
	localparam logic [31:0] GAIN_RST  = 32'h0000_0000;

	// Measurement select and output range codes
	localparam logic [1:0] MEAS_POWER_PIN  = 2'h0;
	localparam logic [1:0] MEAS_SENSE_FREE = 2'h1;
	localparam logic [1:0] MEAS_BUS_FREE   = 2'h2;
	localparam logic [1:0] MEAS_POWER_FREE = 2'h3;
	localparam logic [1:0] FSR_3V0 = 2'h0;
	localparam logic [1:0] FSR_2V0 = 2'h1;
	localparam logic [1:0] FSR_1V5 = 2'h2;
	localparam logic [1:0] FSR_1V0 = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== pms_monitor.sv ====
// Power monitor state control, accumulation, averaging and AXI4-Lite registers
// Contract
// - DAC takes top 10 result bits
// - Four selectable output full-scale ranges
// - Pin high without override means integrate
// - Override set: enable bit high integrates
// - Override set: enable bit low reads
// - Pin low for read time enters read
// - Read stops integration, starts timer, latches DAC
// - DAC updates at each calculation end (count target, read, free-run period), clears in sleep
// - Low beyond sleep time enters sleep
// - Sleep control bit forces sleep
// - Sleep clears results, drops bias
// - Sleep held until integrate commanded
// - Wake reaches integration within wake time
// - Power: sum products, divide by count
// - Power result drives DAC when selected
// - Result LSB is full scale over 1023*64
// - Current and voltage gains scale full scale
// - Results go to DAC and registers
// - Sense mode uses free-run integration
// - Sense: accumulate, average, gain, DAC
// - Period depends on type, resolution, filter, count
// - Two-bit select picks type and mode
// - Free-run latches, restarts, discards partial
// - Sample count capped at 2048
`timescale 1ns/1ps
module pms_monitor #(
	parameter int SAMPLE_W      = 16,
	parameter int READ_CYCLES   = pms_pkg::READ_CYC,
	parameter int SLEEP_CYCLES  = pms_pkg::SLEEP_CYC,
	parameter int WAKE_CYCLES   = pms_pkg::WAKE_CYC,
	parameter int CONV11_CYCLES = pms_pkg::CONV11_CYC,
	parameter int CONV14_CYCLES = pms_pkg::CONV14_CYC
) (
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Host control pin
	input  wire logic                  read_int_pin,
	// Converter samples
	input  wire logic [SAMPLE_W-1:0]   bus_sample,
	input  wire logic [SAMPLE_W-1:0]   sense_sample,
	// Output DAC and power control
	output logic [9:0]                 dac_code,
	output logic [1:0]                 out_range,
	output logic                       bias_enable,
	output logic                       low_power,
	output logic                       integrating
);
	localparam int SW    = SAMPLE_W;
	localparam int CNT_W = 12;
	localparam int ACC_W = 2 * SW + CNT_W;
	localparam int DC_W  = $clog2(ACC_W + 1);
	localparam int TW    = 20;

	if (SW < 10 || SW > 24 || SLEEP_CYCLES >= (1 << (TW - 1)) || READ_CYCLES < 1
		|| WAKE_CYCLES < 1 || CONV11_CYCLES < 1 || CONV14_CYCLES < 1) begin : g_bad_param
		$error("pms_monitor: unsupported parameter value");
	end

	typedef struct packed {
		pms_pkg::pms_state_e pst;
		logic [31:0]         control;
		logic [31:0]         gain;
		logic [TW-1:0]       tmr;
		logic [TW-1:0]       low_cnt;
		logic [TW-1:0]       conv;
		logic [ACC_W-1:0]    acc;
		logic [CNT_W-1:0]    cnt;
		logic                busy;
		logic                hold;
		logic [CNT_W-1:0]    rem;
		logic [DC_W-1:0]     dcnt;
		logic [SW-1:0]       res_pwr;
		logic [SW-1:0]       res_sns;
		logic [SW-1:0]       res_bus;
		logic [9:0]          dac;
		logic                bias_en;
		logic                low_pwr;
		logic                integ;
		logic                awready;
		logic                wready;
		logic [7:0]          awaddr;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} pms_s;

	pms_s s;
	pms_s n;

	logic                ovr;
	logic                sleep_bit;
	logic                ctl;
	logic [1:0]          meas;
	logic                free_run;
	logic [3:0]          smpl_code;
	logic [2:0]          cur_gain;
	logic [2:0]          vol_gain;
	logic [TW-1:0]       sconv;
	logic [TW-1:0]       bconv;
	logic [TW-1:0]       tick_len;
	logic [CNT_W-1:0]    tgt;
	logic [2*SW-1:0]     prod;
	logic [ACC_W-1:0]    add_v;
	logic                go_sleep;
	logic                restart;
	logic                start_calc;
	logic [CNT_W:0]      rem_sh;
	logic [ACC_W-1:0]    quo;
	logic [SW-1:0]       result;
	logic [7:0]          wa;
	logic [7:0]          ra;

	// Saturating digital gain as a left shift
	function automatic logic [SW-1:0] pms_sat(input logic [SW-1:0] v, input logic [3:0] sh);
		logic [SW+14:0] e;
		e = {15'h0, v} << sh;
		if (|e[SW+14:SW]) begin
			return '1;
		end
		return e[SW-1:0];
	endfunction

	// Byte-lane merge
	function automatic logic [31:0] pms_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] st, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r & mask;
	endfunction

	always_comb begin
		n = s;
		go_sleep = 1'b0;
		restart = 1'b0;
		start_calc = 1'b0;
		ovr = s.control[pms_pkg::CTL_OVR];
		sleep_bit = s.control[pms_pkg::CTL_SLEEP];
		meas = s.control[pms_pkg::CTL_MEAS_LO +: 2];
		smpl_code = s.control[pms_pkg::CTL_SMPL_LO +: 4];
		cur_gain = s.gain[pms_pkg::GAIN_CUR_LO +: 3];
		vol_gain = s.gain[pms_pkg::GAIN_VOL_LO +: 3];
		// pin level or enable bit under override
		ctl = ovr ? s.control[pms_pkg::CTL_INT_EN] : read_int_pin;
		// sense and other non-default codes run free
		free_run = (meas != pms_pkg::MEAS_POWER_PIN);

		// conversion time per resolution and filter
		sconv = s.control[pms_pkg::CTL_SRES14] ? TW'(CONV14_CYCLES) : TW'(CONV11_CYCLES);
		if (s.control[pms_pkg::CTL_SFILT]) begin
			sconv = sconv + (sconv >> 1);
		end
		bconv = s.control[pms_pkg::CTL_BRES14] ? TW'(CONV14_CYCLES) : TW'(CONV11_CYCLES);
		if (s.control[pms_pkg::CTL_BFILT]) begin
			bconv = bconv + (bconv >> 1);
		end
		case (meas)
			pms_pkg::MEAS_SENSE_FREE: tick_len = sconv;
			pms_pkg::MEAS_BUS_FREE:   tick_len = bconv;
			default:                  tick_len = sconv + bconv;
		endcase
		if (!free_run || smpl_code >= 4'hb) begin
			tgt = CNT_W'(pms_pkg::MAX_SAMPLES);
		end else begin
			tgt = CNT_W'(1) << smpl_code;
		end

		prod = bus_sample * sense_sample;
		case (meas)
			pms_pkg::MEAS_SENSE_FREE: add_v = ACC_W'(sense_sample);
			pms_pkg::MEAS_BUS_FREE:   add_v = ACC_W'(bus_sample);
			default:                  add_v = ACC_W'(prod);
		endcase

		// Low time of the control level
		if (ctl) begin
			n.low_cnt = '0;
		end else if (s.low_cnt != '1) begin
			n.low_cnt = s.low_cnt + 1'b1;
		end

		case (s.pst)
			pms_pkg::PMS_SLEEP: begin
				if (ctl && !sleep_bit) begin
					n.pst = pms_pkg::PMS_WAKE;
					n.tmr = '0;
				end
			end
			pms_pkg::PMS_WAKE: begin
				if (!ctl || sleep_bit) begin
					go_sleep = 1'b1;
				end else if (s.tmr >= TW'(WAKE_CYCLES - 1)) begin
					n.pst = pms_pkg::PMS_INTEG;
					restart = 1'b1;
				end else begin
					n.tmr = s.tmr + 1'b1;
				end
			end
			pms_pkg::PMS_INTEG: begin
				if (sleep_bit) begin
					go_sleep = 1'b1;
				end else if (!ctl && (ovr || s.low_cnt >= TW'(READ_CYCLES - 1))) begin
					n.pst = pms_pkg::PMS_READ;
					if (free_run) begin
						if (!s.busy) begin
							restart = 1'b1;
						end
					end else if (!s.busy && !s.hold && s.cnt != '0) begin
						start_calc = 1'b1;
					end
				end else if (ctl && !s.busy && !s.hold) begin
					if (s.conv >= tick_len - 1'b1) begin
						n.conv = '0;
						n.acc = s.acc + add_v;
						n.cnt = s.cnt + 1'b1;
						if (n.cnt >= tgt) begin
							start_calc = 1'b1;
						end
					end else begin
						n.conv = s.conv + 1'b1;
					end
				end
			end
			pms_pkg::PMS_READ: begin
				if (sleep_bit || s.low_cnt >= TW'(SLEEP_CYCLES - 1)) begin
					go_sleep = 1'b1;
				end else if (ctl && !s.busy) begin
					n.pst = pms_pkg::PMS_INTEG;
					restart = 1'b1;
				end
			end
			default: n.pst = pms_pkg::PMS_SLEEP;
		endcase

		rem_sh = {s.rem, s.acc[ACC_W-1]};
		quo = {s.acc[ACC_W-2:0], 1'b0};
		if (rem_sh >= {1'b0, s.cnt}) begin
			rem_sh = rem_sh - {1'b0, s.cnt};
			quo[0] = 1'b1;
		end
		case (meas)
			pms_pkg::MEAS_SENSE_FREE: result = pms_sat(quo[SW-1:0], {1'b0, cur_gain});
			pms_pkg::MEAS_BUS_FREE:   result = pms_sat(quo[SW-1:0], {1'b0, vol_gain});
			default: result = pms_sat(quo[2*SW-1:SW], 4'(cur_gain) + 4'(vol_gain));
		endcase
		if (s.busy) begin
			n.acc = quo;
			n.rem = rem_sh[CNT_W-1:0];
			if (s.dcnt == DC_W'(ACC_W - 1)) begin
				n.busy = 1'b0;
				// result and DAC in one edge
				case (meas)
					pms_pkg::MEAS_SENSE_FREE: n.res_sns = result;
					pms_pkg::MEAS_BUS_FREE:   n.res_bus = result;
					default:                  n.res_pwr = result;
				endcase
				n.dac = result[SW-1 -: 10];
				if (free_run) begin
					restart = 1'b1;
				end else begin
					n.hold = (s.pst == pms_pkg::PMS_INTEG);
				end
			end else begin
				n.dcnt = s.dcnt + 1'b1;
			end
		end
		if (start_calc) begin
			n.busy = 1'b1;
			n.dcnt = '0;
			n.rem = '0;
		end
		if (restart) begin
			n.acc = '0;
			n.cnt = '0;
			n.conv = '0;
			n.hold = 1'b0;
		end
		if (go_sleep) begin
			n.pst = pms_pkg::PMS_SLEEP;
			n.acc = '0;
			n.cnt = '0;
			n.conv = '0;
			n.busy = 1'b0;
			n.hold = 1'b0;
			n.res_pwr = '0;
			n.res_sns = '0;
			n.res_bus = '0;
			n.dac = '0;
		end
		n.bias_en = (n.pst != pms_pkg::PMS_SLEEP);
		n.low_pwr = (n.pst == pms_pkg::PMS_READ);
		n.integ = (n.pst == pms_pkg::PMS_INTEG) && !n.busy && !n.hold;

		// AXI write channel
		wa = {s.awaddr[7:2], 2'b00};
		if (s.awready && s_axi_awvalid) begin
			n.awready = 1'b0;
			n.awaddr = s_axi_awaddr;
		end
		if (s.wready && s_axi_wvalid) begin
			n.wready = 1'b0;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (!s.awready && !s.wready && !s.bvalid) begin
			n.bvalid = 1'b1;
			n.bresp = pms_pkg::RESP_OKAY;
			case (wa)
				pms_pkg::ADDR_CONTROL: n.control = pms_merge(s.control, s.wdata, s.wstrb,
					pms_pkg::CTL_MASK);
				pms_pkg::ADDR_GAIN: n.gain = pms_merge(s.gain, s.wdata, s.wstrb,
					pms_pkg::GAIN_MASK);
				pms_pkg::ADDR_STATUS, pms_pkg::ADDR_PWR_RES, pms_pkg::ADDR_SNS_RES,
				pms_pkg::ADDR_BUS_RES, pms_pkg::ADDR_DAC: n.bresp = pms_pkg::RESP_OKAY;
				default: n.bresp = pms_pkg::RESP_SLVERR;
			endcase
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end

		// AXI read channel
		ra = {s_axi_araddr[7:2], 2'b00};
		if (s.arready && s_axi_arvalid) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = pms_pkg::RESP_OKAY;
			case (ra)
				pms_pkg::ADDR_CONTROL: n.rdata = s.control;
				pms_pkg::ADDR_GAIN:    n.rdata = s.gain;
				pms_pkg::ADDR_STATUS:  n.rdata = {16'h0, s.cnt, s.hold, s.busy, s.pst};
				pms_pkg::ADDR_PWR_RES: n.rdata = 32'(s.res_pwr);
				pms_pkg::ADDR_SNS_RES: n.rdata = 32'(s.res_sns);
				pms_pkg::ADDR_BUS_RES: n.rdata = 32'(s.res_bus);
				pms_pkg::ADDR_DAC:     n.rdata = {22'h0, s.dac};
				default: begin
					n.rdata = 32'h0;
					n.rresp = pms_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end

		if (!aresetn) begin
			n = '0;
			n.pst = pms_pkg::PMS_SLEEP;
			n.control = pms_pkg::CTL_RST;
			n.gain = pms_pkg::GAIN_RST;
			n.awready = 1'b1;
			n.wready = 1'b1;
			n.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		s <= n;
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign s_axi_rvalid  = s.rvalid;
	assign dac_code      = s.dac;
	assign out_range     = s.control[pms_pkg::CTL_FSR_LO +: 2];
	assign bias_enable   = s.bias_en;
	assign low_power     = s.low_pwr;
	assign integrating   = s.integ;
endmodule

// ==== pms_monitor_sva.sv ====
// Port checker for the power monitor block
`timescale 1ns/1ps
module pms_monitor_sva #(
	parameter int WAKE_CYCLES = pms_pkg::WAKE_CYC
) (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Bus handshakes
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	// Output and power
	input wire logic [9:0] dac_code,
	input wire logic       bias_enable,
	input wire logic       low_power,
	input wire logic       integrating
);
	localparam int WAKE_MAX = WAKE_CYCLES + 8;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sleep_dac_clear_a: assert property (!bias_enable |-> dac_code == 10'h0)
		else $error("dac code not cleared in sleep");
	dac_after_calc_a: assert property ($changed(dac_code) |-> !$past(integrating) || !bias_enable)
		else $error("dac code changed while accumulating");
	integ_active_a: assert property (integrating |-> bias_enable && !low_power)
		else $error("accumulating outside integrate");
	wake_bound_a: assert property ($rose(bias_enable) |-> ##[1:WAKE_MAX] integrating)
		else $error("no integration after wake");
	write_done_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	bresp_stall_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	read_done_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing");
	rdata_stall_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
endmodule

// ==== pms_host.sv ====
// Host model: control pin and converter samples
`timescale 1ns/1ps
module pms_host (
	// Clock
	input  wire logic        aclk,
	// Requests from the bench
	input  wire logic        want_int,
	input  wire logic [15:0] bus_val,
	input  wire logic [15:0] sense_val,
	// Pin and samples
	output logic             read_int_pin = 1'b0,
	output logic [15:0]      bus_sample   = 16'h0,
	output logic [15:0]      sense_sample = 16'h0
);
	always @(posedge aclk) begin
		read_int_pin <= want_int;
		bus_sample   <= bus_val;
		sense_sample <= sense_val;
	end
endmodule

// ==== tb_power_monitor_state_accumulate.sv ====
// Testbench for the power monitor block
`timescale 1ns/1ps
module tb_power_monitor_state_accumulate;
	logic        aclk, aresetn, want_int, read_int_pin;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, out_range, rs;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, bias_enable, low_power, integrating;
	logic [15:0] bus_sample, sense_sample, bus_val, sense_val;
	logic [9:0]  dac_code;
	int          n_fail, num_checks;

	pms_monitor #(.READ_CYCLES(5), .SLEEP_CYCLES(200), .WAKE_CYCLES(4), .CONV11_CYCLES(2),
		.CONV14_CYCLES(3)) pms_monitor_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .read_int_pin, .bus_sample,
		.sense_sample, .dac_code, .out_range, .bias_enable, .low_power, .integrating);
	pms_host pms_host_inst (.aclk, .want_int, .bus_val, .sense_val, .read_int_pin,
		.bus_sample, .sense_sample);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic timeout(input string what);
		n_fail++;
		$display("CHECK FAILED %s expected done seen timeout", what);
		summarize();
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		timeout("write");
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (v) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		timeout("read");
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
		axi_rd(a, rd, rs);
		check(what, rd, e);
	endtask

	task automatic wait_dac(input logic [9:0] e, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(negedge aclk);
			if (dac_code === e) return;
		end
		timeout("dac update");
	endtask

	// Level select: 0 integrating, 1 read, 2 sleep
	task automatic wait_lvl(input int sel, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(negedge aclk);
			if ((sel == 0 && integrating === 1'b1) || (sel == 1 && low_power === 1'b1) ||
				(sel == 2 && bias_enable === 1'b0)) return;
		end
		timeout("state change");
	endtask

	task automatic t_reset();
		@(negedge aclk);
		check("dac", 32'(dac_code), 32'h0);
		check("bias", 32'(bias_enable), 32'h0);
		rd_chk(pms_pkg::ADDR_CONTROL, pms_pkg::CTL_RST, "control");
		rd_chk(pms_pkg::ADDR_GAIN, pms_pkg::GAIN_RST, "gain");
		axi_rd(8'h1c, rd, rs);
		check("unmapped data", rd, 32'h0);
		check("unmapped rresp", 32'(rs), 32'(pms_pkg::RESP_SLVERR));
		axi_wr(8'h1c, 32'h1, rs);
		check("unmapped bresp", 32'(rs), 32'(pms_pkg::RESP_SLVERR));
		for (int r = 0; r < 4; r++) begin
			axi_wr(pms_pkg::ADDR_CONTROL, 32'(r) << pms_pkg::CTL_FSR_LO, rs);
			@(negedge aclk);
			check("range", 32'(out_range), 32'(r));
		end
	endtask

	task automatic t_free();
		axi_wr(pms_pkg::ADDR_GAIN, 32'h09, rs);
		axi_wr(pms_pkg::ADDR_CONTROL, 32'h10b, rs);
		wait_lvl(0, 40);
		wait_dac(10'h020, 2000);
		rd_chk(pms_pkg::ADDR_SNS_RES, 32'h800, "sense result");
		rd_chk(pms_pkg::ADDR_DAC, 32'h20, "dac register");
		axi_wr(pms_pkg::ADDR_CONTROL, 32'h113, rs);
		wait_dac(10'h018, 2000);
		rd_chk(pms_pkg::ADDR_BUS_RES, 32'h600, "bus result");
		axi_wr(pms_pkg::ADDR_CONTROL, 32'h111, rs);
		wait_lvl(1, 5);
		check("integrating", 32'(integrating), 32'h0);
		axi_wr(pms_pkg::ADDR_CONTROL, 32'h117, rs);
		wait_lvl(2, 10);
		rd_chk(pms_pkg::ADDR_BUS_RES, 32'h0, "bus cleared");
		repeat (30) @(negedge aclk);
		check("asleep", 32'(bias_enable), 32'h0);
	endtask

	task automatic t_power();
		axi_wr(pms_pkg::ADDR_GAIN, 32'h0, rs);
		axi_wr(pms_pkg::ADDR_CONTROL, 32'h0, rs);
		bus_val <= 16'h8000;
		sense_val <= 16'h4000;
		want_int <= 1'b1;
		wait_lvl(0, 40);
		wait_dac(10'h080, 12000);
		check("no read", 32'(low_power), 32'h0);
		@(posedge aclk);
		want_int <= 1'b0;
		wait_lvl(1, 20);
		rd_chk(pms_pkg::ADDR_PWR_RES, 32'h2000, "power result");
		check("dac held", 32'(dac_code), 32'h080);
		wait_lvl(2, 260);
		rd_chk(pms_pkg::ADDR_PWR_RES, 32'h0, "power cleared");
	endtask

	// Power free-run with 14-bit sense and both filters
	task automatic t_rate();
		int len;
		axi_wr(pms_pkg::ADDR_GAIN, 32'h09, rs);
		axi_wr(pms_pkg::ADDR_CONTROL, 32'h681b, rs);
		wait_dac(10'h200, 2000);
		len = 0;
		while (integrating === 1'b1 && len < 100) begin
			len++;
			@(negedge aclk);
		end
		check("period", 32'(len), 32'(3 + 3 / 2 + 2 + 2 / 2));
		rd_chk(pms_pkg::ADDR_PWR_RES, 32'h8000, "free power");
	endtask

	initial begin
		n_fail = 0;
		num_checks = 0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		want_int = 1'b0;
		bus_val = 16'h0300;
		sense_val = 16'h0400;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_free();
		t_power();
		t_rate();
		summarize();
	end
endmodule

bind pms_monitor pms_monitor_sva #(.WAKE_CYCLES(WAKE_CYCLES)) pms_monitor_sva_inst (.aclk,
	.aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .dac_code, .bias_enable, .low_power,
	.integrating);
